// ===== design/i2sf_pkg.sv
// Constants and types shared by the channel-pair formatting block.
// Assumes a 32-bit register bus with byte addresses and one serial link.
package i2sf_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_AUDIO_FORMAT_CONFIG_ONE = 12'hC00;
	localparam logic [11:0] ADDR_CTRL = 12'hC10;
	localparam logic [11:0] ADDR_STAT = 12'hC14;
	localparam logic [11:0] ADDR_TXA = 12'hC20;
	localparam logic [11:0] ADDR_RXA = 12'hC24;
	localparam logic [11:0] ADDR_TXB = 12'hC28;
	localparam logic [11:0] ADDR_RXB = 12'hC2C;

	localparam logic [31:0] AUDIO_FORMAT_CONFIG_ONE_RESET = 32'h0000_0000;
	localparam logic [31:0] AUDIO_FORMAT_CONFIG_ONE_WMASK = 32'h001F_1FC0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h01FF_0003;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int AUDIO_FORMAT_CONFIG_ONE_MODE_LSB = 6;
	localparam int AUDIO_FORMAT_CONFIG_ONE_SWAP_BIT = 8;
	localparam int AUDIO_FORMAT_CONFIG_ONE_ALIGN_BIT = 9;
	localparam int AUDIO_FORMAT_CONFIG_ONE_SINGLE_BIT = 10;
	localparam int AUDIO_FORMAT_CONFIG_ONE_MIC_BIT = 11;
	localparam int AUDIO_FORMAT_CONFIG_ONE_EDGE_BIT = 12;
	localparam int AUDIO_FORMAT_CONFIG_ONE_LEN_LSB = 16;
	localparam int CTRL_RX_BIT = 0;
	localparam int CTRL_EN_BIT = 1;
	localparam int CTRL_POS_LSB = 16;
	localparam int STAT_TXPEND_BIT = 0;
	localparam int STAT_RXFULL_BIT = 1;
	localparam int STAT_UNDER_BIT = 2;
	localparam int STAT_OVER_BIT = 3;
	localparam int POS_RIGHT_BIT = 8;
	localparam int HALF_W = 16;

	// ----------------------------------------------------------------
	// Sample lengths, counters and bus answers
	// ----------------------------------------------------------------
	localparam logic [4:0] LEN_MIN = 5'h03;
	localparam logic [4:0] LEN_PACK_MAX = 5'h0F;
	localparam logic [4:0] LEN_SWAP_MAX = 5'h17;
	localparam logic [4:0] MSB_IDX = 5'h1F;
	localparam logic [4:0] HALF_MSB = 5'h0F;
	localparam logic [9:0] IDX_ONE = 10'h001;
	localparam logic [9:0] IDX_MAX = 10'h3FF;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		I2SF_MODE_CLASSIC = 2'b00,
		I2SF_MODE_DSP_HALF = 2'b01,
		I2SF_MODE_DSP_PULSE = 2'b10,
		I2SF_MODE_DSP_SLOT = 2'b11
	} i2sf_mode_t;

endpackage

// ===== design/i2sf_fmt_if.sv
// Carries settings, FIFO words and samples between the top and the formatter.
// Assumes both ends run on the same clock; the formatter is combinational.
interface i2sf_fmt_if;
	logic [4:0] len;
	logic swap;
	logic msb_align;
	logic pack;
	logic mic;
	logic [31:0] word_a;
	logic [31:0] word_b;
	logic [31:0] pdm_l;
	logic [31:0] pdm_r;
	logic [31:0] rx_left;
	logic [31:0] rx_right;
	logic [31:0] tx_left;
	logic [31:0] tx_right;
	logic [31:0] rx_word_a;
	logic [31:0] rx_word_b;

	modport ctl (
		output len, swap, msb_align, pack, mic, word_a, word_b, pdm_l, pdm_r,
		output rx_left, rx_right,
		input tx_left, tx_right, rx_word_a, rx_word_b
	);
	modport fmt (
		input len, swap, msb_align, pack, mic, word_a, word_b, pdm_l, pdm_r,
		input rx_left, rx_right,
		output tx_left, tx_right, rx_word_a, rx_word_b
	);
endinterface

// ===== design/i2sf_formatter.sv
// Packs and unpacks channel samples between FIFO words and the serializer.
// Assumes effective settings already resolved by the top (swap gating etc).
module i2sf_formatter
	import i2sf_pkg::*;
(
	i2sf_fmt_if.fmt f
);

	// Move a field so that its sample MSB lands on bit 31
	function automatic logic [31:0] to_msb(
		input logic [31:0] field,
		input logic [4:0] fmsb,
		input logic [4:0] len,
		input logic just
	);
		logic [4:0] sh;
		sh = just ? (MSB_IDX - fmsb) : (MSB_IDX - len);
		return field << sh;
	endfunction

	// Place a right-aligned received sample inside its field
	function automatic logic [31:0] place(
		input logic [31:0] smp,
		input logic [4:0] fmsb,
		input logic [4:0] len,
		input logic just
	);
		logic [4:0] sh;
		sh = just ? (fmsb - len) : 5'h00;
		return smp << sh;
	endfunction

	logic [31:0] lo_half;
	logic [31:0] hi_half;
	logic [31:0] rx_lo;
	logic [31:0] rx_hi;

	// Transmit side: pick the halves or words for each channel
	always_comb
	begin
		lo_half = {16'h0000, f.word_a[HALF_W-1:0]};
		hi_half = {16'h0000, f.word_a[31:HALF_W]};
		if (f.mic)
		begin
			// Decimator words arrive right-aligned; swap never applies here
			f.tx_left = to_msb(f.pdm_l, MSB_IDX, f.len, 1'b0);
			f.tx_right = to_msb(f.pdm_r, MSB_IDX, f.len, 1'b0);
		end
		else if (f.pack)
		begin
			// Both channels of one frame share one FIFO entry
			f.tx_right = to_msb(f.swap ? lo_half : hi_half, HALF_MSB, f.len,
				f.msb_align);
			f.tx_left = to_msb(f.swap ? hi_half : lo_half, HALF_MSB, f.len,
				f.msb_align);
		end
		else
		begin
			f.tx_left = to_msb(f.swap ? f.word_b : f.word_a, MSB_IDX, f.len,
				f.msb_align);
			f.tx_right = to_msb(f.swap ? f.word_a : f.word_b, MSB_IDX, f.len,
				f.msb_align);
		end
	end

	// Receive side: rebuild FIFO words from captured samples
	always_comb
	begin
		rx_lo = place(f.swap ? f.rx_right : f.rx_left, HALF_MSB, f.len, f.msb_align);
		rx_hi = place(f.swap ? f.rx_left : f.rx_right, HALF_MSB, f.len, f.msb_align);
		if (f.pack)
		begin
			f.rx_word_a = rx_lo | (rx_hi << HALF_W);
			f.rx_word_b = WORD_ZERO;
		end
		else
		begin
			f.rx_word_a = place(f.swap ? f.rx_right : f.rx_left, MSB_IDX, f.len,
				f.msb_align);
			f.rx_word_b = place(f.swap ? f.rx_left : f.rx_right, MSB_IDX, f.len,
				f.msb_align);
		end
	end

endmodule // i2sf_formatter

// ===== design/i2sf_top.sv
// Channel-pair formatter for a serial audio port, with AXI4-Lite registers.
// Assumes bit clock, word select and serial input come from an outside
// master and are sampled by aclk, which must run several times faster.
//
// The AXI4-Lite slave port was decided locally.

// Behaviour
// - Swap clear: right channel from upper half
// - Swap set: right channel from lower half
// - Align clear: sample right-aligned from bit 0
// - Align set: sample from FIFO word MSB down, or from half MSB (bit 15) when packed
// - Single-channel bit controls first pair only
// - Single-channel: pair data is left channel only
// - Classic single: offset 0x100 starts right half
// - Other modes: single data at offset clock
// - Microphone select picks decimator as transmit source
// - Microphone select refused while receiving
// - Microphone source uses primary pair only
// - Microphone plus single: left sent, right dropped
// - Edge clear: launch falling, sample rising
// - Edge set: launch rising, sample falling
// - Length field is bits minus one, minimum 0x03
// - Classic data starts one clock after word select
// - Swap ignored above 24 bits or with microphone
module i2sf_top
	import i2sf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic bit_clk,
	input wire logic word_sel,
	input wire logic sd_in,
	output logic sd_out,
	output logic sd_oe_n,
	input wire logic [31:0] pdm_left,
	input wire logic [31:0] pdm_right,
	input wire logic pdm_valid,
	output logic other_pairs_idle
);

	// Byte-lane merge limited to writable bits
	function automatic logic [31:0] merge(
		input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb, input logic [31:0] mask
	);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
		return (old & ~m) | (nw & m);
	endfunction

	// Bit offset of idx inside a slot, with hit flag on top
	function automatic logic [5:0] in_slot(
		input logic [9:0] idx, input logic [9:0] start, input logic [4:0] len
	);
		logic [9:0] diff;
		diff = idx - start;
		return {(idx >= start) && (diff <= {5'h00, len}), diff[4:0]};
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	i2sf_fmt_if fi ();
	logic [2:0] sck_q, ws_q, sdi_q;
	logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
	logic awready_q, awready_d, wready_q, wready_d;
	logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic arready_q, arready_d, rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic wr_go, rd_take, wr_hit, rd_hit;
	logic [31:0] rd_val;
	logic [31:0] audio_format_config_one_q, audio_format_config_one_d, ctrl_q, ctrl_d, tx_a_q, tx_a_d, tx_b_q, tx_b_d;
	logic [31:0] rx_a_q, rx_a_d, rx_b_q, rx_b_d, pdm_l_q, pdm_l_d, pdm_r_q, pdm_r_d;
	logic a_w_q, a_w_d, b_w_q, b_w_d, rx_full_q, rx_full_d, pend_q, pend_d;
	logic under_q, under_d, over_q, over_d, idle_q, idle_d;
	logic [9:0] cnt_q, cnt_d, idx, start_l, start_r;
	logic ws_last_q, ws_last_d, sd_out_q, sd_out_d, oe_n_q, oe_n_d, rx_done_q, rx_done_d;
	logic [31:0] txl_q, txl_d, txr_q, txr_d, rxl_q, rxl_d, rxr_q, rxr_d;
	logic [31:0] cur_l, cur_r;
	logic [5:0] sl, sr;
	logic [4:0] len;
	logic [8:0] pos;
	logic classic, single, mic_eff, rx_dir, en, tx_ready, fr_start, boundary;
	logic launch, sample, ws_s, hit_l, hit_r;

	// ----------------------------------------------------------------
	// Settings decode and formatter
	// ----------------------------------------------------------------
	always_comb
	begin
		len = audio_format_config_one_q[AUDIO_FORMAT_CONFIG_ONE_LEN_LSB +: 5];
		if (len < LEN_MIN)
			len = LEN_MIN; // Unsupported short lengths clamp up
		classic = (i2sf_mode_t'(audio_format_config_one_q[AUDIO_FORMAT_CONFIG_ONE_MODE_LSB +: 2]) == I2SF_MODE_CLASSIC);
		single = audio_format_config_one_q[AUDIO_FORMAT_CONFIG_ONE_SINGLE_BIT]; // This block is the first pair
		rx_dir = ctrl_q[CTRL_RX_BIT];
		en = ctrl_q[CTRL_EN_BIT];
		mic_eff = audio_format_config_one_q[AUDIO_FORMAT_CONFIG_ONE_MIC_BIT] & ~rx_dir;
		pos = ctrl_q[CTRL_POS_LSB +: 9];
		tx_ready = a_w_q & (fi.pack | single | b_w_q);
	end

	assign fi.len = len;
	assign fi.swap = audio_format_config_one_q[AUDIO_FORMAT_CONFIG_ONE_SWAP_BIT] & (len <= LEN_SWAP_MAX) & ~mic_eff;
	assign fi.msb_align = audio_format_config_one_q[AUDIO_FORMAT_CONFIG_ONE_ALIGN_BIT];
	assign fi.pack = (len <= LEN_PACK_MAX) & ~single & ~mic_eff;
	assign fi.mic = mic_eff;
	assign fi.word_a = tx_a_q;
	assign fi.word_b = tx_b_q;
	assign fi.pdm_l = pdm_l_q;
	assign fi.pdm_r = pdm_r_q;
	assign fi.rx_left = rxl_q;
	assign fi.rx_right = rxr_q;

	i2sf_formatter u_fmt (
		.f(fi)
	);

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	assign wr_go = aw_have_q & w_have_q & ~bvalid_q;
	assign rd_take = arvalid & arready_q;

	// Read decode; unmapped addresses answer with a slave error
	always_comb
	begin
		rd_hit = 1'b1;
		case (araddr)
			ADDR_AUDIO_FORMAT_CONFIG_ONE: rd_val = audio_format_config_one_q;
			ADDR_CTRL: rd_val = ctrl_q;
			ADDR_STAT: rd_val = {28'h000_0000, over_q, under_q, rx_full_q, tx_ready};
			ADDR_TXA: rd_val = tx_a_q;
			ADDR_TXB: rd_val = tx_b_q;
			ADDR_RXA: rd_val = rx_a_q;
			ADDR_RXB: rd_val = rx_b_q;
			default:
			begin
				rd_val = WORD_ZERO;
				rd_hit = 1'b0;
			end
		endcase
		wr_hit = (aw_addr_q == ADDR_AUDIO_FORMAT_CONFIG_ONE) | (aw_addr_q == ADDR_CTRL) |
			(aw_addr_q == ADDR_STAT) | (aw_addr_q == ADDR_TXA) | (aw_addr_q == ADDR_TXB);
	end

	// Channel handshakes; address and data may come in either order
	always_comb
	begin
		aw_have_d = (aw_have_q | (awvalid & awready_q)) & ~wr_go;
		w_have_d = (w_have_q | (wvalid & wready_q)) & ~wr_go;
		aw_addr_d = (awvalid & awready_q) ? awaddr : aw_addr_q;
		w_data_d = (wvalid & wready_q) ? wdata : w_data_q;
		w_strb_d = (wvalid & wready_q) ? wstrb : w_strb_q;
		bvalid_d = wr_go | (bvalid_q & ~bready);
		bresp_d = wr_go ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : bresp_q;
		awready_d = ~aw_have_d & ~bvalid_d;
		wready_d = ~w_have_d & ~bvalid_d;
		rvalid_d = rd_take | (rvalid_q & ~rready);
		arready_d = ~rvalid_d;
		rdata_d = rd_take ? rd_val : rdata_q;
		rresp_d = rd_take ? (rd_hit ? RESP_OKAY : RESP_SLVERR) : rresp_q;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= WORD_ZERO;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			rvalid_q <= 1'b0;
			arready_q <= 1'b0;
			rdata_q <= WORD_ZERO;
			rresp_q <= RESP_OKAY;
		end
		else
		begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			aw_addr_q <= aw_addr_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			rvalid_q <= rvalid_d;
			arready_q <= arready_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// ----------------------------------------------------------------
	// Registers, holding words and flags
	// ----------------------------------------------------------------
	always_comb
	begin
		audio_format_config_one_d = audio_format_config_one_q;
		ctrl_d = ctrl_q;
		tx_a_d = tx_a_q;
		tx_b_d = tx_b_q;
		a_w_d = a_w_q;
		b_w_d = b_w_q;
		under_d = under_q;
		over_d = over_q;
		// A frame start consumes the held words; a write in that cycle still counts
		if (fr_start & ~mic_eff & tx_ready)
		begin
			a_w_d = 1'b0;
			b_w_d = 1'b0;
		end
		if (wr_go)
		begin
			case (aw_addr_q)
				ADDR_AUDIO_FORMAT_CONFIG_ONE: audio_format_config_one_d = merge(audio_format_config_one_q, w_data_q, w_strb_q, AUDIO_FORMAT_CONFIG_ONE_WMASK);
				ADDR_CTRL: ctrl_d = merge(ctrl_q, w_data_q, w_strb_q, CTRL_WMASK);
				ADDR_TXA:
				begin
					tx_a_d = merge(tx_a_q, w_data_q, w_strb_q, {32{1'b1}});
					a_w_d = 1'b1;
				end
				ADDR_TXB:
				begin
					tx_b_d = merge(tx_b_q, w_data_q, w_strb_q, {32{1'b1}});
					b_w_d = 1'b1;
				end
				ADDR_STAT:
				begin
					under_d = under_q & ~(w_strb_q[0] & w_data_q[STAT_UNDER_BIT]);
					over_d = over_q & ~(w_strb_q[0] & w_data_q[STAT_OVER_BIT]);
				end
				default: ;
			endcase
		end
		// Microphone source cannot coexist with receive direction
		if (ctrl_d[CTRL_RX_BIT])
			audio_format_config_one_d[AUDIO_FORMAT_CONFIG_ONE_MIC_BIT] = 1'b0;
		// Late or missing data is flagged; sets beat clears
		if (fr_start & ~(mic_eff ? pend_q : tx_ready))
			under_d = 1'b1;
		if ((pdm_valid & pend_q & ~(fr_start & mic_eff)) | (rx_done_q & rx_full_q))
			over_d = 1'b1;
		pend_d = pdm_valid | (pend_q & ~(fr_start & mic_eff));
		pdm_l_d = pdm_valid ? pdm_left : pdm_l_q;
		pdm_r_d = pdm_valid ? pdm_right : pdm_r_q;
		rx_full_d = rx_done_q | (rx_full_q & ~(rd_take & (araddr == ADDR_RXA)));
		rx_a_d = rx_done_q ? fi.rx_word_a : rx_a_q;
		rx_b_d = rx_done_q ? fi.rx_word_b : rx_b_q;
		idle_d = mic_eff; // Secondary pairs are held off
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			audio_format_config_one_q <= AUDIO_FORMAT_CONFIG_ONE_RESET;
			ctrl_q <= CTRL_RESET;
			{tx_a_q, tx_b_q, rx_a_q, rx_b_q} <= {4{WORD_ZERO}};
			{pdm_l_q, pdm_r_q} <= {2{WORD_ZERO}};
			{a_w_q, b_w_q, rx_full_q, pend_q, under_q, over_q, idle_q} <= 7'h00;
		end
		else
		begin
			audio_format_config_one_q <= audio_format_config_one_d;
			ctrl_q <= ctrl_d;
			{tx_a_q, tx_b_q, rx_a_q, rx_b_q} <= {tx_a_d, tx_b_d, rx_a_d, rx_b_d};
			{pdm_l_q, pdm_r_q} <= {pdm_l_d, pdm_r_d};
			{a_w_q, b_w_q, rx_full_q, pend_q} <= {a_w_d, b_w_d, rx_full_d, pend_d};
			{under_q, over_q, idle_q} <= {under_d, over_d, idle_d};
		end
	end

	// ----------------------------------------------------------------
	// Serial link
	// ----------------------------------------------------------------
	// Two stages before use; bit 2 keeps the last bit clock for edges
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sck_q <= 3'b000;
			ws_q <= 3'b000;
			sdi_q <= 3'b000;
		end
		else
		begin
			sck_q <= {sck_q[1:0], bit_clk};
			ws_q <= {ws_q[1:0], word_sel};
			sdi_q <= {sdi_q[1:0], sd_in};
		end
	end

	always_comb
	begin
		ws_s = ws_q[1];
		// Launch and sample edges follow the edge select
		launch = audio_format_config_one_q[AUDIO_FORMAT_CONFIG_ONE_EDGE_BIT] ? (sck_q[1] & ~sck_q[2]) : (~sck_q[1] & sck_q[2]);
		sample = audio_format_config_one_q[AUDIO_FORMAT_CONFIG_ONE_EDGE_BIT] ? (~sck_q[1] & sck_q[2]) : (sck_q[1] & ~sck_q[2]);
		// Classic restarts the count at each word-select edge
		boundary = classic ? (ws_s != ws_last_q) : (ws_last_q & ~ws_s);
		idx = boundary ? '0 : cnt_q;
		fr_start = launch & ws_last_q & ~ws_s & en & ~rx_dir;
		if (classic & single)
			start_l = {2'b00, pos[7:0]} + IDX_ONE;
		else if (classic)
			start_l = {1'b0, pos} + IDX_ONE;
		else
			start_l = {1'b0, pos};
		start_r = classic ? start_l : start_l + {5'h00, len} + IDX_ONE;
		sl = in_slot(idx, start_l, len);
		sr = in_slot(idx, start_r, len);
		// Single channel keeps only the left slot, placed by the offset
		hit_l = sl[5] & (~classic | (single ? (ws_s == pos[POS_RIGHT_BIT]) : ~ws_s));
		hit_r = sr[5] & ~single & (~classic | ws_s); // Right dropped when single
		cur_l = fr_start ? fi.tx_left : txl_q;
		cur_r = fr_start ? fi.tx_right : txr_q;
	end

	always_comb
	begin
		cnt_d = cnt_q;
		ws_last_d = ws_last_q;
		sd_out_d = sd_out_q;
		oe_n_d = oe_n_q;
		txl_d = cur_l;
		txr_d = cur_r;
		rxl_d = rxl_q;
		rxr_d = rxr_q;
		rx_done_d = 1'b0;
		if (launch)
		begin
			oe_n_d = ~(en & ~rx_dir & (hit_l | hit_r));
			sd_out_d = hit_l ? cur_l[MSB_IDX - sl[4:0]] : (hit_r & cur_r[MSB_IDX - sr[4:0]]);
		end
		if (sample)
		begin
			ws_last_d = ws_s;
			cnt_d = (idx == IDX_MAX) ? idx : idx + IDX_ONE;
			if (en & rx_dir & hit_l)
			begin
				rxl_d = (sl[4:0] == 5'h00) ? {31'h0, sdi_q[1]} : {rxl_q[30:0], sdi_q[1]};
				rx_done_d = single & (sl[4:0] == len);
			end
			if (en & rx_dir & hit_r)
			begin
				rxr_d = (sr[4:0] == 5'h00) ? {31'h0, sdi_q[1]} : {rxr_q[30:0], sdi_q[1]};
				rx_done_d = (sr[4:0] == len);
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_q <= '0;
			{ws_last_q, sd_out_q, rx_done_q} <= 3'b000;
			oe_n_q <= 1'b1;
			{txl_q, txr_q, rxl_q, rxr_q} <= {4{WORD_ZERO}};
		end
		else
		begin
			cnt_q <= cnt_d;
			{ws_last_q, sd_out_q, rx_done_q} <= {ws_last_d, sd_out_d, rx_done_d};
			oe_n_q <= oe_n_d;
			{txl_q, txr_q, rxl_q, rxr_q} <= {txl_d, txr_d, rxl_d, rxr_d};
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign sd_out = sd_out_q;
	assign sd_oe_n = oe_n_q;
	assign other_pairs_idle = idle_q;

endmodule // i2sf_top

// ===== bench/i2sf_check_sva.sv
// Checker for bus handshakes and serial output timing of the formatter.
// Assumes it is bound to i2sf_top and sees only that module's ports.
module i2sf_check
	import i2sf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic bit_clk,
	input wire logic sd_out,
	input wire logic sd_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// --------
	// Cycles since the raw bit clock last moved
	// --------
	logic bclk_q;
	logic [3:0] quiet_q;
	logic [3:0] quiet_d;
	// Saturates so a long idle never wraps back into the window
	always_comb
	begin
		quiet_d = (quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1;
		if (bit_clk != bclk_q)
			quiet_d = 4'h0;
	end
	always_ff @(posedge aclk)
	begin
		bclk_q <= bit_clk;
		quiet_q <= (!aresetn) ? 4'hF : quiet_d;
	end

	// --------
	// Assertions
	// --------
	wr_resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	rd_resp_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	rd_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write answer late");
	rd_block_a: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	wr_block_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answer pending");
	cfg_read_a: assert property (arvalid && arready && araddr == ADDR_AUDIO_FORMAT_CONFIG_ONE
		|=> rresp == RESP_OKAY && (rdata & ~AUDIO_FORMAT_CONFIG_ONE_WMASK) == WORD_ZERO)
		else $error("configuration read wrong");
	bad_read_a: assert property (arvalid && arready && araddr == 12'h000
		|=> rresp == RESP_SLVERR && rdata == WORD_ZERO)
		else $error("unmapped read not refused");
	sd_launch_a: assert property ($changed(sd_out) || $changed(sd_oe_n)
		|-> quiet_q <= 4'h5)
		else $error("serial output moved away from a clock edge");
	reset_out_a: assert property (disable iff (1'b0) !aresetn |=> !bvalid && !rvalid && sd_oe_n)
		else $error("outputs not reset");
	cover property (bvalid && bready);
	cover property (rvalid && rresp == RESP_SLVERR);
	cover property ($fell(sd_oe_n));
endmodule // i2sf_check

bind i2sf_top i2sf_check chk_u (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
	.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
	.rready, .bit_clk, .sd_out, .sd_oe_n);

// ===== bench/i2sf_codec_model.sv
// Model of the outside link master: bit clock, word select and data.
// Assumes one frame of 64 clocks per call; clock stands still between frames.
module i2sf_codec_model (
	output logic bit_clk,
	output logic word_sel,
	output logic sd_in,
	input wire logic sd_out,
	input wire logic sd_oe_n,
	input wire logic [63:0] rx_frame,
	output logic [63:0] cap
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle between frames: word select high, clock at its idle level
	initial
	begin
		bit_clk = 1'b1;
		word_sel = 1'b1;
		sd_in = 1'b0;
		cap = '0;
	end

	// One frame; bit i of the frame sits at vector bit 63-i
	task automatic frame(input logic pol);
		// Pin edges sit off the bench clock edges so the synchroniser never races them
		#5 bit_clk = ~pol;
		#300;
		for (int i = 0; i < 64; i++)
		begin
			bit_clk = pol; // Launch edge
			word_sel = (i >= 32);
			sd_in = rx_frame[63-i];
			#100 bit_clk = ~pol; // Sample edge
			// Taken late in the bit: the output lags the pin edge by a few cycles
			#99 cap[63-i] = sd_out & ~sd_oe_n;
			#1;
		end
		sd_in = ~sd_in; // Released line shows no stale level
	endtask
endmodule // i2sf_codec_model

// ===== bench/i2s_channel_pair_formatting_test.sv
// Self-checking bench for the channel-pair formatter.
// Assumes the codec model drives the link and AXI4-Lite reaches registers.
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
	$display("[FAIL] %0t got %h want %h", $time, a, b); end end
module i2s_channel_pair_formatting_test;
	import i2sf_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, bit_clk, word_sel, sd_in, sd_out;
	logic sd_oe_n, pdm_valid, other_pairs_idle;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, pdm_left, pdm_right;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [63:0] rx_frame, cap;
	int n_errors = 0;
	int samples_checked = 0;

	i2sf_top dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .bit_clk, .word_sel, .sd_in, .sd_out, .sd_oe_n, .pdm_left,
		.pdm_right, .pdm_valid, .other_pairs_idle);
	i2sf_codec_model codec_u (.bit_clk, .word_sel, .sd_in, .sd_out, .sd_oe_n, .rx_frame, .cap);

	// --------
	// Bus tasks
	// --------
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// One transmit frame, compared bit for bit; undriven bits read as 0
	task automatic run_tx(input logic [31:0] cfg, ctl, txa, input logic pol, input logic [63:0] e);
		wr(ADDR_CTRL, ctl);
		wr(ADDR_AUDIO_FORMAT_CONFIG_ONE, cfg);
		wr(ADDR_TXA, txa);
		codec_u.frame(pol);
		@(posedge aclk);
		`CHK(cap, e)
	endtask

	// --------
	// Scenarios
	// --------
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rd(ADDR_AUDIO_FORMAT_CONFIG_ONE, d, r);
		`CHK(d, AUDIO_FORMAT_CONFIG_ONE_RESET)
		wr(ADDR_AUDIO_FORMAT_CONFIG_ONE, 32'hFFFF_FFFF);
		rd(ADDR_AUDIO_FORMAT_CONFIG_ONE, d, r);
		`CHK(d, AUDIO_FORMAT_CONFIG_ONE_WMASK)
		rd(12'h000, d, r);
		`CHK(r, RESP_SLVERR)
	endtask

	// Swap clear then set with both channels in use; swap with single channel is not driven here
	task automatic t_swap();
		run_tx(32'h000F_0000, 32'h2, 32'hA5A5_3C3C, 1'b0, {1'b0, 16'h3C3C, 15'h0, 1'b0, 16'hA5A5, 15'h0});
		run_tx(32'h000F_1100, 32'h2, 32'hA5A5_3C3C, 1'b1, {1'b0, 16'hA5A5, 15'h0, 1'b0, 16'h3C3C, 15'h0});
	endtask

	task automatic t_align();
		run_tx(32'h0007_0200, 32'h2, 32'h5A00_C300, 1'b0, {1'b0, 8'hC3, 23'h0, 1'b0, 8'h5A, 23'h0});
	endtask

	task automatic t_single();
		run_tx(32'h000F_0400, 32'h0104_0002, 32'h0000_9C63, 1'b0, {37'h0, 16'h9C63, 11'h0});
	endtask

	task automatic t_mode();
		run_tx(32'h000F_0480, 32'h0003_0002, 32'h0000_0F0F, 1'b0, {3'h0, 16'h0F0F, 45'h0});
	endtask

	// One decimator sample per frame keeps the rates equal
	task automatic t_mic();
		logic [31:0] d;
		logic [1:0] r;
		wr(ADDR_CTRL, 32'h2);
		wr(ADDR_AUDIO_FORMAT_CONFIG_ONE, 32'h000F_0C00);
		`CHK(other_pairs_idle, 1'b1)
		pdm_left <= 32'h0000_7E81;
		pdm_right <= 32'h0000_1BAD;
		pdm_valid <= 1'b1;
		@(posedge aclk);
		pdm_valid <= 1'b0;
		run_tx(32'h000F_0C00, 32'h2, 32'h0000_0000, 1'b0, {1'b0, 16'h7E81, 47'h0});
		// No fresh decimator sample for the next frame, so underrun must be flagged
		codec_u.frame(1'b0);
		@(posedge aclk);
		rd(ADDR_STAT, d, r);
		`CHK(d[STAT_UNDER_BIT], 1'b1)
	endtask

	task automatic t_rx();
		logic [31:0] d;
		logic [1:0] r;
		wr(ADDR_CTRL, 32'h3);
		wr(ADDR_AUDIO_FORMAT_CONFIG_ONE, 32'h000F_0800);
		rd(ADDR_AUDIO_FORMAT_CONFIG_ONE, d, r);
		`CHK(d, 32'h000F_0000)
		`CHK(other_pairs_idle, 1'b0)
		rx_frame = {1'b0, 16'h1234, 15'h0, 1'b0, 16'hABCD, 15'h0};
		codec_u.frame(1'b0);
		@(posedge aclk);
		rd(ADDR_RXA, d, r);
		`CHK(d, 32'hABCD_1234)
	endtask

	task automatic wrap_up();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// --------
	// Clock, watchdog and main sequence
	// --------
	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// Eight frames of about 13 us each plus bus traffic fit well inside
	initial
	begin
		#400us;
		n_errors++;
		wrap_up();
	end

	initial
	begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, pdm_valid} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hF;
		pdm_left = '0;
		pdm_right = '0;
		rx_frame = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_swap();
		t_align();
		t_single();
		t_mode();
		t_mic();
		t_rx();
		wrap_up();
	end
endmodule // i2s_channel_pair_formatting_test
